// ==== hdl/pld_core.sv ====
// Power-loss controlled stop sequencer and analog window comparators
//
// Added by the designer: the plain strobed port and the placing of the registers.
`include "pld_regs.svh"

module pld_core
    import pld_pkg::*;
(
    input  wire logic        clk,                 // 25 MHz clock
    input  wire logic        rst_n,               // Synchronous reset, active low
    input  wire logic [3:0]  reg_addr,            // Register word address
    input  wire logic [31:0] reg_wdata,           // Write data
    input  wire logic        reg_wr,              // Write strobe
    input  wire logic        reg_rd,              // Read strobe
    output logic      [31:0] reg_rdata,           // Read data, cycle after strobe
    input  wire logic        run,                 // Drive is in run mode
    input  wire logic [13:0] bus_voltage,         // DC bus, volts x10
    input  wire logic [13:0] uv_level,            // Undervoltage level, volts x10
    input  wire logic [12:0] run_freq,            // Commanded frequency, hertz x10
    input  wire logic [6:0]  voltage_analog_input,// Voltage input, percent
    input  wire logic [6:0]  current_analog_input,// Current input, percent
    output logic      [12:0] out_freq,            // Output frequency, hertz x10
    output logic             drive_enable,        // Low removes drive (coast)
    output logic             uv_trip,             // Undervoltage trip, sticky
    output logic             decel_active,        // Sequence in progress
    output logic             restart_request,     // Mode 3 finished, restart allowed
    output logic             voltage_input_window_flag,      // Voltage window flag
    output logic             current_input_window_flag,      // Current window flag
    output logic             voltage_input_disconnect_flag,  // Equals voltage window flag
    output logic             current_input_disconnect_flag,  // Equals current window flag
    output logic      [6:0]  voltage_input_effective,        // Voltage input after substitution
    output logic      [6:0]  current_input_effective,        // Current input after substitution
    output logic      [7:0]  ambient_temperature_setting     // Ambient for fan-life estimate
);

    // ************************************************************
    // Setting registers
    // ************************************************************
    pld_mode_e   power_loss_mode_select;
    logic [13:0] bus_trigger_level;
    logic [13:0] bus_overvoltage_pause_level;
    logic [18:0] controlled_decel_time;
    logic [6:0]  initial_frequency_drop;
    logic [6:0]  win_upper [2];
    logic [6:0]  win_lower [2];
    logic [6:0]  win_hyst  [2];
    logic [7:0]  subst     [2];
    logic        win_flag  [2];
    pld_state_e  state;

    // Clamp a volts setting to the legal range
    function automatic logic [13:0] clamp_volt(input logic [31:0] v);
        clamp_volt = (v[31:14] != 18'h00000 || v[13:0] > `PLD_MAX_VOLT) ? `PLD_MAX_VOLT : v[13:0];
    endfunction

    // Clamp a percent field to at most lim
    function automatic logic [6:0] clamp_pct(input logic [7:0] v, input logic [6:0] lim);
        clamp_pct = (v > {1'b0, lim}) ? lim : v[6:0];
    endfunction

    // Settings writes; out-of-range values saturate, substitutes above 100 become the ignore code, so logic never sees them
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            power_loss_mode_select      <= pld_mode_e'(`PLD_RST_MODE);
            bus_trigger_level           <= `PLD_RST_TRIG;
            bus_overvoltage_pause_level <= `PLD_RST_OVP;
            controlled_decel_time       <= `PLD_RST_DECEL;
            initial_frequency_drop      <= `PLD_RST_DROP;
            ambient_temperature_setting <= `PLD_RST_AMBIENT;
            for (int i = 0; i < 2; i++) begin
                win_upper[i] <= `PLD_RST_WUPPER;
                win_lower[i] <= `PLD_RST_WLOWER;
                win_hyst[i]  <= `PLD_RST_WHYST;
                subst[i]     <= `PLD_RST_SUBST;
            end
        end else if (reg_wr) begin
            case (reg_addr)
                `PLD_A_MODE:  power_loss_mode_select <= pld_mode_e'(reg_wdata[1:0]);
                `PLD_A_TRIG:  bus_trigger_level <= clamp_volt(reg_wdata);
                `PLD_A_OVP:   bus_overvoltage_pause_level <= clamp_volt(reg_wdata);
                `PLD_A_DECEL: begin
                    if (reg_wdata[31:19] != 13'h0000 || reg_wdata[18:0] > `PLD_MAX_DECEL)
                        controlled_decel_time <= `PLD_MAX_DECEL;
                    else if (reg_wdata[18:0] < `PLD_MIN_DECEL)
                        controlled_decel_time <= `PLD_MIN_DECEL;
                    else
                        controlled_decel_time <= reg_wdata[18:0];
                end
                `PLD_A_DROP:  initial_frequency_drop <= clamp_pct(reg_wdata[7:0], `PLD_MAX_DROP);
                `PLD_A_VWIN, `PLD_A_IWIN: begin
                    win_upper[reg_addr[1]] <= clamp_pct(reg_wdata[7:0], `PLD_MAX_PCT);
                    win_lower[reg_addr[1]] <= clamp_pct(reg_wdata[15:8], `PLD_MAX_PCT);
                    win_hyst[reg_addr[1]]  <= clamp_pct(reg_wdata[23:16], `PLD_MAX_HYST);
                end
                `PLD_A_SUBST: begin
                    subst[0] <= (reg_wdata[7:0] > 8'h64) ? `PLD_SUBST_IGNORE : reg_wdata[7:0];
                    subst[1] <= (reg_wdata[15:8] > 8'h64) ? `PLD_SUBST_IGNORE : reg_wdata[15:8];
                end
                `PLD_A_AMBIENT: begin
                    if ($signed(reg_wdata[7:0]) < $signed(`PLD_AMB_MIN))
                        ambient_temperature_setting <= `PLD_AMB_MIN;
                    else if ($signed(reg_wdata[7:0]) > $signed(`PLD_AMB_MAX))
                        ambient_temperature_setting <= `PLD_AMB_MAX;
                    else
                        ambient_temperature_setting <= reg_wdata[7:0];
                end
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Control copies swap when pause level sits below trigger; stored values stay
    logic        levels_swapped;
    logic [13:0] ctl_trig;
    logic [13:0] ctl_ovp;
    assign levels_swapped = bus_overvoltage_pause_level < bus_trigger_level;
    assign ctl_trig = levels_swapped ? bus_overvoltage_pause_level : bus_trigger_level;
    assign ctl_ovp  = levels_swapped ? bus_trigger_level : bus_overvoltage_pause_level;

    // Ramp timing: one 0.1 Hz frequency step every decel_time ticks of 0.01 s.
    // Slope is 0.1 Hz per (decel_time x 0.01 s); simple fixed rate vs full scale.
    logic [17:0] tick_cnt;
    logic        tick;
    logic [18:0] step_cnt;
    logic        step;
    assign tick = tick_cnt == 18'(`PLD_TICK_CYC - 1);
    assign step = tick && (step_cnt + 19'h00001 >= controlled_decel_time);

    // Hundredth-second tick divider
    always_ff @(posedge clk) begin
        if (!rst_n || tick)
            tick_cnt <= 18'h00000;
        else
            tick_cnt <= tick_cnt + 18'h00001;
    end

    // Decel time counts ticks per 0.1 Hz step
    always_ff @(posedge clk) begin
        if (!rst_n || state != PLD_RAMP)
            step_cnt <= 19'h00000;
        else if (step)
            step_cnt <= 19'h00000;
        else if (tick)
            step_cnt <= step_cnt + 19'h00001;
    end

    logic under_trig;
    logic at_ovp;
    logic under_uv;
    logic use_busctl;
    assign under_trig = bus_voltage <= ctl_trig;
    assign at_ovp     = bus_voltage >= ctl_ovp;
    assign under_uv   = bus_voltage <= uv_level;
    assign use_busctl = power_loss_mode_select == PLD_MODE_BUSCTL ||
                        power_loss_mode_select == PLD_MODE_BUSCTL_RESTART;

    // Sequence state; no exit back to idle until frequency reaches zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= PLD_IDLE;
        end else begin
            case (state)
                PLD_IDLE: begin
                    if (run && under_trig)
                        state <= (power_loss_mode_select == PLD_MODE_TRIP) ? PLD_TRIPPED : PLD_DROP;
                end
                PLD_DROP: state <= PLD_RAMP;
                PLD_RAMP: begin
                    if (under_uv)
                        state <= PLD_TRIPPED;
                    else if (out_freq == 13'h0000)
                        state <= PLD_DONE;
                    else if (use_busctl && at_ovp)
                        state <= PLD_PAUSE;
                end
                PLD_PAUSE: begin
                    if (under_uv)
                        state <= PLD_TRIPPED;
                    else if (under_trig)
                        state <= PLD_RAMP;
                end
                PLD_TRIPPED: if (!run) state <= PLD_IDLE;
                PLD_DONE:    if (!run) state <= PLD_IDLE;
                default: state <= PLD_IDLE;
            endcase
        end
    end

    // Output frequency: follow command when idle, then drop and ramp
    always_ff @(posedge clk) begin
        if (!rst_n)
            out_freq <= 13'h0000;
        else if (state == PLD_IDLE)
            out_freq <= run ? run_freq : 13'h0000;
        else if (state == PLD_DROP)
            out_freq <= (out_freq > 13'(initial_frequency_drop)) ?
                        out_freq - 13'(initial_frequency_drop) : 13'h0000;
        else if (state == PLD_RAMP && step && out_freq != 13'h0000)
            out_freq <= out_freq - 13'h0001;
        else if (state == PLD_TRIPPED)
            out_freq <= 13'h0000;
    end

    // Trip flag sticks until run drops; drive removed while tripped
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            uv_trip         <= 1'b0;
            drive_enable    <= 1'b0;
            decel_active    <= 1'b0;
            restart_request <= 1'b0;
        end else begin
            uv_trip         <= (state == PLD_TRIPPED) || ((state == PLD_RAMP ||
                               state == PLD_PAUSE) && under_uv);
            drive_enable    <= run && state != PLD_TRIPPED && state != PLD_DONE;
            decel_active    <= state == PLD_DROP || state == PLD_RAMP || state == PLD_PAUSE;
            restart_request <= state == PLD_DONE &&
                               power_loss_mode_select == PLD_MODE_BUSCTL_RESTART;
        end
    end

    // ************************************************************
    // Window comparators
    // ************************************************************
    logic [6:0] ain [2];
    logic [6:0] eff [2];
    assign ain[0] = voltage_analog_input;
    assign ain[1] = current_analog_input;

    // Flag sets only a hysteresis width inside the window, clears as soon as the input leaves the window
    generate
        for (genvar g = 0; g < 2; g++) begin : g_win
            logic [7:0] up_in;
            logic [7:0] lo_in;
            // Saturate so a band wider than the upper limit cannot wrap to a huge bound
            assign up_in = (win_upper[g] > win_hyst[g]) ?
                           {1'b0, win_upper[g]} - {1'b0, win_hyst[g]} : 8'h00;
            assign lo_in = {1'b0, win_lower[g]} + {1'b0, win_hyst[g]};
            always_ff @(posedge clk) begin
                if (!rst_n)
                    win_flag[g] <= 1'b0;
                else if (!win_flag[g])
                    win_flag[g] <= {1'b0, ain[g]} <= up_in && {1'b0, ain[g]} >= lo_in;
                else
                    win_flag[g] <= ain[g] <= win_upper[g] && ain[g] >= win_lower[g];
            end
            always_ff @(posedge clk) begin
                if (!rst_n)
                    eff[g] <= 7'h00;
                else if (win_flag[g] && subst[g] != `PLD_SUBST_IGNORE)
                    eff[g] <= subst[g][6:0];
                else
                    eff[g] <= ain[g];
            end
        end
    endgenerate

    assign voltage_input_window_flag     = win_flag[0];
    assign current_input_window_flag     = win_flag[1];
    assign voltage_input_disconnect_flag = win_flag[0];
    assign current_input_disconnect_flag = win_flag[1];
    assign voltage_input_effective       = eff[0];
    assign current_input_effective       = eff[1];

    // ************************************************************
    // Read-back
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `PLD_A_MODE:    reg_rdata <= {30'h0, power_loss_mode_select};
                `PLD_A_TRIG:    reg_rdata <= {18'h0, bus_trigger_level};
                `PLD_A_OVP:     reg_rdata <= {18'h0, bus_overvoltage_pause_level};
                `PLD_A_DECEL:   reg_rdata <= {13'h0, controlled_decel_time};
                `PLD_A_DROP:    reg_rdata <= {25'h0, initial_frequency_drop};
                `PLD_A_VWIN, `PLD_A_IWIN:
                    reg_rdata <= {9'h0, win_hyst[reg_addr[1]], 1'b0, win_lower[reg_addr[1]],
                                  1'b0, win_upper[reg_addr[1]]};
                `PLD_A_SUBST:   reg_rdata <= {16'h0, subst[1], subst[0]};
                `PLD_A_AMBIENT: reg_rdata <= {24'h0, ambient_temperature_setting};
                `PLD_A_STATUS:  reg_rdata <= {26'h0, restart_request, win_flag[1], win_flag[0],
                                              uv_trip, state == PLD_PAUSE, decel_active};
                `PLD_A_FREQ:    reg_rdata <= {19'h0, out_freq};
                default:        reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_drop_follows_start: assert property (@(posedge clk) disable iff (!rst_n)
        state == PLD_IDLE && run && under_trig && power_loss_mode_select != PLD_MODE_TRIP
        |=> state == PLD_DROP ##1 state == PLD_RAMP)
        else $error("drop step not taken after trigger");
    a_pause_holds_freq: assert property (@(posedge clk) disable iff (!rst_n)
        state == PLD_PAUSE |=> $stable(out_freq))
        else $error("frequency moved during pause");
    a_pause_on_ovp: assert property (@(posedge clk) disable iff (!rst_n)
        state == PLD_RAMP && use_busctl && at_ovp && !under_uv && out_freq != 13'h0000
        |=> state == PLD_PAUSE)
        else $error("no pause at overvoltage level");
    a_resume_on_trig: assert property (@(posedge clk) disable iff (!rst_n)
        state == PLD_PAUSE && under_trig && !under_uv |=> state == PLD_RAMP)
        else $error("ramp not resumed at trigger");
    a_uv_coasts: assert property (@(posedge clk) disable iff (!rst_n)
        (state == PLD_RAMP || state == PLD_PAUSE) && under_uv
        |=> uv_trip ##1 !drive_enable && out_freq == 13'h0000)
        else $error("undervoltage did not trip");
    a_swap_levels: assert property (@(posedge clk) disable iff (!rst_n)
        ctl_trig <= ctl_ovp)
        else $error("control levels not ordered");
    a_no_abort: assert property (@(posedge clk) disable iff (!rst_n)
        state == PLD_RAMP && !under_uv && out_freq != 13'h0000 |=> state != PLD_IDLE)
        else $error("sequence aborted early");
    a_ramp_monotone: assert property (@(posedge clk) disable iff (!rst_n)
        state == PLD_RAMP && !step |=> $stable(out_freq))
        else $error("ramp stepped without rate tick");
    a_disc_equal: assert property (@(posedge clk) disable iff (!rst_n)
        current_input_disconnect_flag == current_input_window_flag)
        else $error("disconnect flag differs from window flag");
    a_subst_used: assert property (@(posedge clk) disable iff (!rst_n)
        win_flag[0] && subst[0] != `PLD_SUBST_IGNORE |=> eff[0] == $past(subst[0][6:0]))
        else $error("substitute not applied");
    a_hyst_capped: assert property (@(posedge clk) disable iff (!rst_n)
        win_hyst[0] <= `PLD_MAX_HYST && win_hyst[1] <= `PLD_MAX_HYST)
        else $error("hysteresis above cap");
    a_trip_mode_direct: assert property (@(posedge clk) disable iff (!rst_n)
        state == PLD_IDLE && run && under_trig && power_loss_mode_select == PLD_MODE_TRIP
        |=> state == PLD_TRIPPED && !decel_active)
        else $error("trip mode did not trip at trigger");
    a_window_clears: assert property (@(posedge clk) disable iff (!rst_n)
        ain[0] > win_upper[0] || ain[0] < win_lower[0] |=> !win_flag[0])
        else $error("flag stayed set outside window");
    a_window_holds_off: assert property (@(posedge clk) disable iff (!rst_n)
        !win_flag[0] && {1'b0, ain[0]} < {1'b0, win_lower[0]} + {1'b0, win_hyst[0]}
        |=> !win_flag[0])
        else $error("flag set inside hysteresis band");

    c_pause_resume: cover property (@(posedge clk) disable iff (!rst_n)
        state == PLD_PAUSE ##1 state == PLD_RAMP);
    c_done: cover property (@(posedge clk) disable iff (!rst_n) state == PLD_DONE);
    c_uv_trip: cover property (@(posedge clk) disable iff (!rst_n) $rose(uv_trip));
    c_window: cover property (@(posedge clk) disable iff (!rst_n) $rose(win_flag[1]));
    c_restart: cover property (@(posedge clk) disable iff (!rst_n) $rose(restart_request));

endmodule

// ==== hdl/pld_regs.svh ====
// Register offsets, field positions, reset values and timing counts for the power-loss block
`ifndef PLD_REGS_SVH
`define PLD_REGS_SVH

// Register map, word addresses on the plain register port
`define PLD_A_MODE        4'h0
`define PLD_A_TRIG        4'h1
`define PLD_A_OVP         4'h2
`define PLD_A_DECEL       4'h3
`define PLD_A_DROP        4'h4
`define PLD_A_VWIN        4'h5
`define PLD_A_IWIN        4'h6
`define PLD_A_SUBST       4'h7
`define PLD_A_AMBIENT     4'h8
`define PLD_A_STATUS      4'h9
`define PLD_A_FREQ        4'ha

// Reset values (volts x10, hundredths of a second, hertz x10, percent)
`define PLD_RST_MODE      2'h0
`define PLD_RST_TRIG      14'h0898
`define PLD_RST_OVP       14'h0e10
`define PLD_RST_DECEL     19'h00064
`define PLD_RST_DROP      7'h00
`define PLD_RST_WUPPER    7'h64
`define PLD_RST_WLOWER    7'h00
`define PLD_RST_WHYST     7'h00
`define PLD_RST_SUBST     8'hff
`define PLD_RST_AMBIENT   8'h28

// Setting limits
`define PLD_MAX_VOLT      14'h2710
`define PLD_MIN_DECEL     19'h00001
`define PLD_MAX_DECEL     19'h57e40
`define PLD_MAX_DROP      7'h64
`define PLD_MAX_PCT       7'h64
`define PLD_MAX_HYST      7'h0a
`define PLD_SUBST_IGNORE  8'hff
`define PLD_AMB_MIN       8'hf6
`define PLD_AMB_MAX       8'h32

// Timing: one hundredth of a second in 40 ns cycles
`define PLD_TICK_NS       32'd10000000
`define PLD_CLK_NS        32'd40
`define PLD_TICK_CYC      (`PLD_TICK_NS / `PLD_CLK_NS)

// Status bit positions
`define PLD_ST_ACTIVE     0
`define PLD_ST_PAUSE      1
`define PLD_ST_UVTRIP     2
`define PLD_ST_VWIN       3
`define PLD_ST_IWIN       4
`define PLD_ST_RESTART    5

`endif

// ==== hdl/pld_pkg.sv ====
// Types shared by the power-loss deceleration and window compare block
package pld_pkg;
    typedef enum logic [1:0] {
        PLD_MODE_TRIP,
        PLD_MODE_DECEL,
        PLD_MODE_BUSCTL,
        PLD_MODE_BUSCTL_RESTART
    } pld_mode_e;

    typedef enum logic [2:0] {
        PLD_IDLE,
        PLD_DROP,
        PLD_RAMP,
        PLD_PAUSE,
        PLD_TRIPPED,
        PLD_DONE
    } pld_state_e;
endpackage

// ==== verif/pld_src_model.sv ====
// Far-side model of the DC bus sensing path seen by the block
module pld_src_model (
    input  wire logic        clk,         // Bench clock
    input  wire logic [13:0] bus_set,     // Bus level the scenario asks for
    output logic      [13:0] bus_voltage  // Bus level as sensed, one cycle late
);
    timeunit 1ns;
    timeprecision 1ps;
    // Sensor lag of one cycle, so the block never sees a step in the driving edge
    initial bus_voltage = 14'h1388;
    always @(posedge clk) begin
        bus_voltage <= bus_set;
    end
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the power-loss sequencer and window comparators
`include "pld_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, run = 0, rd_seen = 0;
    logic [3:0]  reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, lfsr = 32'h66c8;
    logic [13:0] bus_set = 14'h1388, bus_voltage, uv_level = 14'h05dc;
    logic [12:0] run_freq = 0, out_freq;
    logic [6:0]  vin = 7'h32, iin = 7'h32, veff, ieff;
    logic [7:0]  amb;
    logic        drive_enable, uv_trip, decel_active, restart, vflag, iflag, vdisc, idisc;
    logic [6:0]  wv [6] = '{7'h32, 7'h0a, 7'h17, 7'h1a, 7'h4d, 7'h51};
    logic        wf [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [31:0] exp_q [$];
    int          fails = 0, checks_done = 0;

    pld_src_model src (.clk(clk), .bus_set(bus_set), .bus_voltage(bus_voltage));
    pld_core dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .run(run),
        .bus_voltage(bus_voltage), .uv_level(uv_level), .run_freq(run_freq),
        .voltage_analog_input(vin), .current_analog_input(iin), .out_freq(out_freq),
        .drive_enable(drive_enable), .uv_trip(uv_trip), .decel_active(decel_active),
        .restart_request(restart), .voltage_input_window_flag(vflag),
        .current_input_window_flag(iflag), .voltage_input_disconnect_flag(vdisc),
        .current_input_disconnect_flag(idisc), .voltage_input_effective(veff),
        .current_input_effective(ieff), .ambient_temperature_setting(amb));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Settle one step past the edge so sampled outputs never race the design
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1; reg_addr <= a; exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 0;
    endtask
    task automatic bus(input logic [13:0] v, input int n);
        @(posedge clk);
        bus_set <= v;
        cyc(n);
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 0; run <= 0; bus_set <= 14'h1388; // Healthy bus, no stale trigger
        repeat (16) @(posedge clk);
        rst_n <= 1;
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // ****************************************
    // Clock, read monitor, watchdog, sequence
    // ****************************************
    initial forever #20 clk = ~clk;
    // Read data stand only in the cycle after the strobe, so compare exactly there
    always @(posedge clk) begin
        if (rd_seen) check(reg_rdata, exp_q.pop_front());
        rd_seen <= reg_rd;
    end
    // A hang costs a mismatch rather than an endless run
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        conclude();
    end
    initial begin
        do_reset();
        rd(`PLD_A_MODE, 0); rd(`PLD_A_TRIG, 32'h898); rd(`PLD_A_OVP, 32'he10);
        rd(`PLD_A_DECEL, 32'h64); rd(`PLD_A_DROP, 0);
        rd(`PLD_A_SUBST, 32'hffff); rd(`PLD_A_AMBIENT, 32'h28); rd(4'hf, 0);
        $display("test defaults done");
        wr(`PLD_A_TRIG, 32'hffff); rd(`PLD_A_TRIG, 32'h2710);
        wr(`PLD_A_OVP, 32'hffff); rd(`PLD_A_OVP, 32'h2710);
        wr(`PLD_A_DECEL, 0); rd(`PLD_A_DECEL, 1);
        wr(`PLD_A_DROP, 32'h7f); rd(`PLD_A_DROP, 32'h64);
        wr(`PLD_A_SUBST, 32'hc8c8); rd(`PLD_A_SUBST, 32'hffff);
        wr(`PLD_A_VWIN, 32'h140064); rd(`PLD_A_VWIN, 32'h0a0064);
        wr(`PLD_A_AMBIENT, 32'h3c); rd(`PLD_A_AMBIENT, 32'h32);
        cyc(2); check(amb, 8'h32);
        do_reset();
        $display("test limits done");
        run <= 1;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            lfsr = lfsr_next(lfsr);
            run_freq <= lfsr[11:0]; iin <= lfsr[6:0] % 7'd101;
            cyc(3);
            check(out_freq, run_freq);
            check(iflag, 1); check(idisc, 1);
            check(ieff, iin);
        end
        bus(14'h07d0, 4); check(drive_enable, 0); check(decel_active, 0);
        do_reset();
        $display("test idle and trip done");
        wr(`PLD_A_MODE, 2); wr(`PLD_A_TRIG, 32'hbb8); wr(`PLD_A_DROP, 32'h14);
        run_freq <= 13'h64; run <= 1; iin <= 7'h32;
        bus(14'h1388, 3); check(out_freq, 13'h64);
        bus(14'h0b54, 5); check(out_freq, 13'h50); check(decel_active, 1);
        bus(14'h0e74, 4); rd(`PLD_A_STATUS, 32'h1b);
        bus(14'h1388, 4); rd(`PLD_A_STATUS, 32'h1b);
        bus(14'h0b54, 4); rd(`PLD_A_STATUS, 32'h19);
        bus(14'h03e8, 4); check(uv_trip, 1); check(drive_enable, 0);
        check(out_freq, 0);
        do_reset(); // Operator drops run only after the coast-down
        wr(`PLD_A_MODE, 3); wr(`PLD_A_TRIG, 32'hbb8); wr(`PLD_A_OVP, 32'h7d0);
        wr(`PLD_A_DROP, 32'h64); // Full drop from 10 Hz stops the motor at once
        bus(14'h1388, 2); @(posedge clk); run <= 1;
        bus(14'h09c4, 4); check(decel_active, 0);
        bus(14'h07d0, 4); check(decel_active, 1); rd(`PLD_A_OVP, 32'h7d0);
        cyc(1); check(restart, 1); check(out_freq, 0);
        do_reset();
        $display("test sequencer done");
        wr(`PLD_A_VWIN, 32'h051450); wr(`PLD_A_SUBST, 32'hff1e);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            vin <= wv[i];
            cyc(3);
            check(vflag, wf[i]);
            check(vdisc, wf[i]);
            check(veff, wf[i] ? 7'h1e : wv[i]);
        end
        $display("test window done");
        conclude();
    end
endmodule
